// ### core/usart_tx_map.svh
// Purpose: Constants for the transmit framing and control block
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef USART_TX_MAP_SVH
`define USART_TX_MAP_SVH
// Char length field codes (5..8 bits)
`define CHAR_LEN_5BIT  2'h0
`define CHAR_LEN_6BIT  2'h1
`define CHAR_LEN_7BIT  2'h2
`define CHAR_LEN_8BIT  2'h3
// Parity kind codes
`define PAR_EVEN       3'h0
`define PAR_ODD        3'h1
`define PAR_SPACE      3'h2
`define PAR_MARK       3'h3
// Stop bit count codes
`define STOP_ONE       2'h0
`define STOP_ONE_HALF  2'h1
`define STOP_TWO       2'h2
// Half-bit ticks per bit
`define HALF_PER_BIT   4'h2
// Fifo depth
`define TX_FIFO_DEPTH  8
`endif

// ### core/usart_tx_pkg.sv
// Purpose: Types for the transmit framing and control block
// Assumes: None
// Notes:   Gray coded states along start-data-parity-stop-guard
package usart_tx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_DATA   = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP   = 3'h6,
    ST_GUARD  = 3'h7
  } txState_t;
endpackage

// ### core/usart_tx_fifo.sv
// Purpose: Holding buffer between software writes and the shifter
// Assumes: Single clock, synchronous reset
// Notes:   Flush empties it without touching contents
`timescale 1ns/100ps
`default_nettype none
module usart_tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule
`default_nettype wire

// ### core/usart_enable_tx_framing.sv
// Purpose: Receiver/transmitter enable control and transmit framing
// Assumes: Serial clock given as a one-cycle tick on falling edges
// Notes:   Receiver framing lives outside; this holds its enable
`timescale 1ns/100ps
`default_nettype none
`include "usart_tx_map.svh"
module usart_enable_tx_framing
  import usart_tx_pkg::*;
#(
  parameter int DATA_W     = 9,
  parameter int FIFO_DEPTH = `TX_FIFO_DEPTH,
  parameter int GUARD_W    = 8
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Command strobes, one-cycle pulses
  input  wire logic              cmdWrite,
  input  wire logic              receive_enable,
  input  wire logic              receive_disable,
  input  wire logic              receive_soft_reset,
  input  wire logic              transmit_enable,
  input  wire logic              transmit_disable,
  input  wire logic              transmit_soft_reset,
  // Mode configuration
  input  wire logic [1:0]        char_length_field,
  input  wire logic              nine_bit_select,
  input  wire logic [2:0]        check_bit_kind,
  input  wire logic              high_bit_first,
  input  wire logic [1:0]        stop_bit_count,
  input  wire logic              clocked_mode_select,
  input  wire logic [GUARD_W-1:0] guardTime,
  // Serial clock ticks
  input  wire logic              serialHalfTick,
  // Transmit holding write
  input  wire logic              holdValid,
  output logic                   holdReady,
  input  wire logic [DATA_W-1:0] holdData,
  // Receiver status from outside framer
  input  wire logic              rxCharBusy,
  // Status
  output logic                   rxEnabled,
  output logic                   txEnabled,
  output logic                   txEmpty,
  output logic                   txHoldReady,
  // Serial line
  output logic                   serial_out_pin
);
  ////////////////////////////////////////////////////////////////////////////
  logic              receive_enable_q;
  logic              rxStopPend_q;
  logic              transmit_enable_q;
  logic              txStopPend_q;
  txState_t          state_q;
  logic [DATA_W-1:0] shift_q;
  logic [3:0]        bitCnt_q;
  logic [3:0]        nBits_q;
  logic              parity_q;
  logic [2:0]        halfCnt_q;
  logic [GUARD_W-1:0] guardCnt_q;
  logic              txOut_q;
  logic              fifoValid;
  logic              fifoTake;
  logic [DATA_W-1:0] fifoData;
  logic [3:0]        dataLen;
  logic [2:0]        stopHalves;
  logic              bitEnd;
  logic              txBusy;

  function automatic logic [3:0] lenOf(input logic [1:0] lenCode, input logic nine);
    lenOf = nine ? 4'h9 : 4'h5 + {2'h0, lenCode};
  endfunction

  assign dataLen = lenOf(char_length_field, nine_bit_select);
  // Async mode is clocked_mode_select low
  assign stopHalves = (stop_bit_count == `STOP_TWO) ? 3'h4 :
                      ((stop_bit_count == `STOP_ONE_HALF) && !clocked_mode_select)
                      ? 3'h3 : 3'h2;
  assign bitEnd = serialHalfTick && (halfCnt_q == 3'h1);
  assign txBusy = (state_q != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Receiver enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      receive_enable_q       <= 1'b0;
      rxStopPend_q <= 1'b0;
    end else if (cmdWrite && receive_soft_reset) begin
      rxStopPend_q <= 1'b0;
    end else begin
      if (rxStopPend_q && !rxCharBusy) begin
        receive_enable_q       <= 1'b0;
        rxStopPend_q <= 1'b0;
      end
      // A fresh command wins over a pending stop
      if (cmdWrite && receive_disable) begin
        rxStopPend_q <= 1'b1;
      end else if (cmdWrite && receive_enable) begin
        receive_enable_q       <= 1'b1;
        rxStopPend_q <= 1'b0;
      end
    end
  end
  assign rxEnabled = receive_enable_q && !(rxStopPend_q && !rxCharBusy);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      transmit_enable_q       <= 1'b0;
      txStopPend_q <= 1'b0;
    end else if (cmdWrite && transmit_soft_reset) begin
      txStopPend_q <= 1'b0;
    end else begin
      if (txStopPend_q && !txBusy && !fifoValid) begin
        transmit_enable_q       <= 1'b0;
        txStopPend_q <= 1'b0;
      end
      // A fresh command wins over a pending stop
      if (cmdWrite && transmit_disable) begin
        txStopPend_q <= 1'b1;
      end else if (cmdWrite && transmit_enable) begin
        transmit_enable_q       <= 1'b1;
        txStopPend_q <= 1'b0;
      end
    end
  end
  assign txEnabled = transmit_enable_q;

  ////////////////////////////////////////////////////////////////////////////
  // Holding buffer
  usart_tx_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .flush    (cmdWrite && transmit_soft_reset),
    .inValid  (holdValid),
    .inReady  (holdReady),
    .inData   (holdData),
    .outValid (fifoValid),
    .outReady (fifoTake),
    .outData  (fifoData)
  );
  assign txHoldReady = holdReady;
  assign txEmpty     = !txBusy && !fifoValid;
  // Draining continues while a disable is pending
  assign fifoTake = transmit_enable_q && !txBusy && serialHalfTick;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer, same in sync and async modes except that 1.5 stop bits send one stop bit in sync mode
  always_ff @(posedge mclk) begin
    if (sys_rst || (cmdWrite && transmit_soft_reset)) begin
      state_q    <= ST_IDLE;
      shift_q    <= '0;
      bitCnt_q   <= 4'h0;
      nBits_q    <= 4'h0;
      parity_q   <= 1'b0;
      halfCnt_q  <= 3'h0;
      guardCnt_q <= '0;
      txOut_q    <= 1'b1;
    end else if (serialHalfTick) begin
      halfCnt_q <= (halfCnt_q == 3'h0) ? 3'h0 : halfCnt_q - 3'h1;
      unique case (state_q)
        ST_IDLE: begin
          if (fifoTake && fifoValid) begin
            shift_q   <= fifoData;
            nBits_q   <= dataLen;
            bitCnt_q  <= 4'h0;
            parity_q  <= 1'b0;
            txOut_q   <= 1'b0;
            halfCnt_q <= 3'(`HALF_PER_BIT);
            state_q   <= ST_START;
          end
        end
        ST_START: begin
          if (bitEnd) begin
            txOut_q   <= high_bit_first ? shift_q[nBits_q-4'h1] : shift_q[0];
            halfCnt_q <= 3'(`HALF_PER_BIT);
            state_q   <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (bitEnd) begin
            parity_q  <= parity_q ^ txOut_q;
            halfCnt_q <= 3'(`HALF_PER_BIT);
            bitCnt_q  <= bitCnt_q + 4'h1;
            if (bitCnt_q + 4'h1 == nBits_q) begin
              if (check_bit_kind[2]) begin
                txOut_q   <= 1'b1;
                halfCnt_q <= stopHalves;
                state_q   <= ST_STOP;
              end else begin
                state_q <= ST_PARITY;
                unique case (check_bit_kind[1:0])
                  2'h0: txOut_q <= parity_q ^ txOut_q;
                  2'h1: txOut_q <= ~(parity_q ^ txOut_q);
                  2'h2: txOut_q <= 1'b0;
                  2'h3: txOut_q <= 1'b1;
                endcase
              end
            end else if (high_bit_first) begin
              txOut_q <= shift_q[nBits_q-4'h2-bitCnt_q];
            end else begin
              txOut_q <= shift_q[bitCnt_q+4'h1];
            end
          end
        end
        ST_PARITY: begin
          if (bitEnd) begin
            txOut_q   <= 1'b1;
            halfCnt_q <= stopHalves;
            state_q   <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (serialHalfTick && halfCnt_q == 3'h1) begin
            guardCnt_q <= guardTime;
            state_q    <= (guardTime != '0) ? ST_GUARD : ST_IDLE;
          end
        end
        ST_GUARD: begin
          guardCnt_q <= guardCnt_q - 1'b1;
          if (guardCnt_q == {{(GUARD_W-1){1'b0}}, 1'b1}) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  assign serial_out_pin = txOut_q;
endmodule
`default_nettype wire

// ### testbench/usart_tx_properties.sv
// Purpose: Port checks on the transmit framing block
// Assumes: One clock, synchronous reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module usart_tx_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Commands
  input wire logic cmdWrite,
  input wire logic receive_enable,
  input wire logic receive_disable,
  input wire logic receive_soft_reset,
  input wire logic transmit_enable,
  input wire logic transmit_disable,
  input wire logic transmit_soft_reset,
  // Line side and status
  input wire logic serialHalfTick,
  input wire logic holdReady,
  input wire logic rxCharBusy,
  input wire logic rxEnabled,
  input wire logic txEnabled,
  input wire logic txEmpty,
  input wire logic serial_out_pin
);
  logic txRstCmd;
  assign txRstCmd = cmdWrite && transmit_soft_reset;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  property p_rstOff; $fell(sys_rst) |-> !rxEnabled && !txEnabled && serial_out_pin; endproperty
  a_rstOff: assert property (p_rstOff) else $error("units active after reset");
  property p_rxOn;
    cmdWrite && receive_enable && !receive_disable && !receive_soft_reset |=> rxEnabled;
  endproperty
  a_rxOn: assert property (p_rxOn) else $error("receiver not enabled");
  property p_txOn;
    cmdWrite && transmit_enable && !transmit_disable && !transmit_soft_reset |=> txEnabled;
  endproperty
  a_txOn: assert property (p_txOn) else $error("transmitter not enabled");
  property p_rxRise; $rose(rxEnabled) |-> $past(cmdWrite && receive_enable); endproperty
  a_rxRise: assert property (p_rxRise) else $error("receiver enabled without command");
  property p_rxHold; rxEnabled && rxCharBusy |=> rxEnabled || !rxCharBusy; endproperty
  a_rxHold: assert property (p_rxHold) else $error("receiver stopped mid character");
  property p_rxDrop;
    cmdWrite && receive_disable && !receive_soft_reset && !rxCharBusy |=> ##[0:1] !rxEnabled;
  endproperty
  a_rxDrop: assert property (p_rxDrop) else $error("receiver did not stop");
  property p_txHold; txEnabled && !txEmpty |=> txEnabled; endproperty
  a_txHold: assert property (p_txHold) else $error("transmitter stopped with data held");
  property p_start; $fell(serial_out_pin) |-> $past(serialHalfTick && txEnabled); endproperty
  a_start: assert property (p_start) else $error("start bit off tick or disabled");
  property p_onTick;
    $changed(serial_out_pin) |-> $past(serialHalfTick) || $past(txRstCmd) || $past(txRstCmd, 2);
  endproperty
  a_onTick: assert property (p_onTick) else $error("line changed off tick");
  property p_abort; txRstCmd |-> ##1 serial_out_pin && txEmpty; endproperty
  a_abort: assert property (p_abort) else $error("soft reset did not abort");
  c_frame: cover property ($fell(serial_out_pin));
  c_full: cover property (!holdReady);
  c_rxWait: cover property (cmdWrite && receive_disable && rxCharBusy && rxEnabled);
endmodule
bind usart_enable_tx_framing usart_tx_checker usart_tx_checker_i (.*);
`default_nettype wire

// ### testbench/serial_peer.sv
// Purpose: Remote receiver decoding the serial line
// Assumes: Samples mid bit, two ticks per bit
// Notes:   Frame holds data, parity and stop samples, first bit at 0
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // Line
  input  wire logic        serialHalfTick,
  input  wire logic        serial_out_pin,
  // Result
  input  wire logic [3:0]  nBits,
  output var  logic [15:0] frame,
  output var  logic        gotFrame
);
  logic [4:0] n;
  logic       busy;
  always_ff @(posedge mclk) begin
    gotFrame <= 1'b0;
    if (sys_rst) begin
      busy <= 1'b0;
      frame <= 16'h0000;
    end else if (serialHalfTick && !busy && !serial_out_pin) begin
      busy <= 1'b1;
      n <= 5'h00;
      frame <= 16'h0000;
    end else if (serialHalfTick && busy) begin
      n <= n + 5'h01;
      if (n[0]) begin
        frame[n[4:1]] <= serial_out_pin;
        if (n[4:1] == nBits - 4'h1) begin
          busy <= 1'b0;
          gotFrame <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Purpose: Self-checking bench for the transmit framing block
// Assumes: Half-bit tick every fourth clock
// Notes:   Serial peer decodes each frame
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk, sys_rst, cmdWrite, holdValid, holdReady, rxCharBusy;
  logic        receive_enable, receive_disable, receive_soft_reset;
  logic        transmit_enable, transmit_disable, transmit_soft_reset;
  logic        nine_bit_select, high_bit_first, clocked_mode_select;
  logic [1:0]  char_length_field, stop_bit_count;
  logic [2:0]  check_bit_kind;
  logic [7:0]  guardTime;
  logic [8:0]  holdData;
  logic        serialHalfTick = 1'b0;
  logic [1:0]  tickDiv = 2'h0;
  logic        rxEnabled, txEnabled, txEmpty, txHoldReady, serial_out_pin, gotFrame;
  logic [15:0] frame;
  logic [3:0]  nBits;
  int          bad_count, n_compared;
  usart_enable_tx_framing usart_enable_tx_framing_i (.*);
  serial_peer serial_peer_i (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    tickDiv <= tickDiv + 2'h1;
    serialHalfTick <= (tickDiv == 2'h3);
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input logic [5:0] bits);
    @(negedge mclk);
    cmdWrite = 1'b1;
    {receive_enable, receive_disable, receive_soft_reset} = bits[5:3];
    {transmit_enable, transmit_disable, transmit_soft_reset} = bits[2:0];
    @(negedge mclk);
    cmdWrite = 1'b0;
  endtask
  task automatic push(input logic [8:0] d);
    @(negedge mclk);
    holdValid = 1'b1;
    holdData = d;
    @(negedge mclk);
    holdValid = 1'b0;
  endtask
  function automatic logic [15:0] frame_for(input logic [8:0] d, output logic [3:0] nb);
    int len;
    logic p;
    logic [15:0] f;
    len = nine_bit_select ? 9 : 5 + char_length_field;
    f = 16'hffff;
    p = 1'b0;
    for (int i = 0; i < len; i++) begin
      f[i] = high_bit_first ? d[len-1-i] : d[i];
      p = p ^ d[i];
    end
    if (!check_bit_kind[2]) f[len] = check_bit_kind[1] ? check_bit_kind[0] : p ^ check_bit_kind[0];
    nb = 4'(len + !check_bit_kind[2] + (stop_bit_count == 2'h2 ? 2 : 1));
    return f & ((16'h1 << nb) - 16'h1);
  endfunction
  task automatic expect_tx(input logic [8:0] d);
    logic [15:0] e;
    logic [3:0] nb;
    int k;
    e = frame_for(d, nb);
    nBits = nb;
    k = 0;
    while (gotFrame !== 1'b1 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k == 3000) begin
      bad_count++;
      final_report();
    end
    chk("frame", e, frame);
    @(negedge mclk);
  endtask
  task automatic frame_case(input logic [9:0] c, input logic [8:0] d);
    {nine_bit_select, char_length_field, check_bit_kind} = c[9:4];
    {high_bit_first, stop_bit_count, clocked_mode_select} = c[3:0];
    push(d);
    expect_tx(d);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    cmdWrite = 1'b0;
    {receive_enable, receive_disable, receive_soft_reset} = 3'h0;
    {transmit_enable, transmit_disable, transmit_soft_reset} = 3'h0;
    {nine_bit_select, char_length_field, check_bit_kind, high_bit_first} = 7'h3c;
    {stop_bit_count, clocked_mode_select, rxCharBusy, holdValid} = 5'h00;
    {guardTime, holdData, nBits} = 21'h0_0000;
    bad_count = 0;
    n_compared = 0;
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    chk("idle", 16'h0007, {rxEnabled, txEnabled, txEmpty, serial_out_pin, holdReady});
    push(9'h0a5);
    repeat (40) @(negedge mclk);
    chk("held", 16'h0001, {txEnabled, serial_out_pin});
    cmd(6'h24);
    chk("enables", 16'h0003, {rxEnabled, txEnabled});
    expect_tx(9'h0a5);
    frame_case(10'b0_00_000_0_00_0, 9'h013);
    frame_case(10'b0_01_001_1_10_0, 9'h02d);
    frame_case(10'b0_10_010_0_01_0, 9'h055);
    frame_case(10'b0_11_011_1_01_1, 9'h0c3);
    frame_case(10'b1_00_000_0_00_0, 9'h1a7);
    frame_case(10'b1_10_100_1_00_1, 9'h15a);
    frame_case(10'b1_10_100_1_00_0, 9'h15a);
    frame_case(10'b0_11_101_0_11_0, 9'h0f0);
    {nine_bit_select, char_length_field, check_bit_kind, high_bit_first} = 7'h3c;
    guardTime = 8'h06;
    push(9'h011);
    push(9'h022);
    cmd(6'h02);
    chk("draining", 16'h0001, txEnabled);
    expect_tx(9'h011);
    expect_tx(9'h022);
    repeat (40) @(negedge mclk);
    chk("stopped", 16'h0000, txEnabled);
    push(9'h000);
    cmd(6'h04);
    repeat (30) @(negedge mclk);
    cmd(6'h01);
    @(negedge mclk);
    chk("aborted", 16'h0007, {serial_out_pin, txEmpty, txEnabled});
    repeat (120) @(negedge mclk);
    rxCharBusy = 1'b1;
    cmd(6'h10);
    repeat (5) @(negedge mclk);
    chk("rx busy", 16'h0001, rxEnabled);
    rxCharBusy = 1'b0;
    repeat (3) @(negedge mclk);
    chk("rx off", 16'h0000, rxEnabled);
    cmd(6'h00);
    chk("zero cmd", 16'h0001, {rxEnabled, txEnabled});
    cmd(6'h20);
    cmd(6'h08);
    chk("rx reset", 16'h0003, {rxEnabled, txEnabled});
    cmd(6'h10);
    chk("rx idle off", 16'h0001, {rxEnabled, txEnabled});
    cmd(6'h02);
    for (int i = 0; i < 8; i++) push(9'(i + 'h40));
    chk("full", 16'h0000, {holdReady, txHoldReady});
    cmd(6'h04);
    for (int i = 0; i < 8; i++) expect_tx(9'(i + 'h40));
    repeat (40) @(negedge mclk);
    chk("empty", 16'h0003, {txEmpty, holdReady});
    final_report();
  end
endmodule
`default_nettype wire
